/* rtl/sdp_pkg.sv */
// Constants, command set and reset states of the SDRAM pin interface.
// Assumes one 100 MHz system clock; the memory clock is that clock halved.
package sdp_pkg;

  // Pin widths
  localparam int ADDR_W  = 13;
  localparam int DQ_W    = 32;
  localparam int BANK_W  = 2;
  localparam int CHIPS   = 2;
  localparam int MASK_W  = 4;

  // Pin levels once reset has ended
  localparam logic [ADDR_W-1:0] ADDR_POST = 13'h0000;
  localparam logic [DQ_W-1:0]   DQ_POST   = 32'hffff_ffff;
  localparam logic [BANK_W-1:0] BANK_POST = 2'h0;
  localparam logic [CHIPS-1:0]  CS_POST   = 2'h3;
  localparam logic [MASK_W-1:0] MASK_POST = 4'h0;
  localparam logic              CLK_POST  = 1'h0;
  localparam logic              CKE_POST  = 1'h1;
  localparam logic [2:0]        STRB_POST = 3'h7;

  // Timing: memory clocks from read command to data at the pins
  localparam logic [2:0] CAS_LAT_CLKS = 3'h2;
  // Two extra rising edges: command sample plus pin synchroniser
  localparam logic [2:0] RD_CAP_TICK  = CAS_LAT_CLKS + 3'h2;

  typedef enum logic [2:0] {
    CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_REF, CMD_MRS
  } sdp_cmd_t;

  typedef enum logic [1:0] {
    ST_PWR_RESET, ST_SYS_RESET, ST_WAIT_LOCK, ST_RUN
  } sdp_rst_state_t;

  // Strobe levels {row, col, write}, all active low
  function automatic logic [2:0] sdp_cmd_pins(input sdp_cmd_t c);
    logic [2:0] p;
    p = STRB_POST;
    unique case (c)
      CMD_ACT: p = 3'h3;
      CMD_RD:  p = 3'h5;
      CMD_WR:  p = 3'h4;
      CMD_PRE: p = 3'h2;
      CMD_REF: p = 3'h1;
      CMD_MRS: p = 3'h0;
      default: p = STRB_POST;
    endcase
    return p;
  endfunction : sdp_cmd_pins

endpackage : sdp_pkg

/* rtl/sdp_pin_if.sv */
// Pin-level SDRAM interface: reset sequencing, forwarded clock, command pins, data bus.
// Assumes reset pins and PLL lock arrive asynchronously; the pad ring resolves the enables.
//
// Overview of operation
// - Power-on reset input low means power-up reset, whatever system reset shows.
// - Power-on high with system reset low means system reset.
// - Post-reset levels apply only with both resets high and PLL locked.
// - In either reset every memory pin, forwarded clock included, floats.
// - 13-bit address drives row/column location; low after reset.
// - 32-bit two-way data bus; driven high after reset.
// - Outputs launched for the forwarded clock's rising edge; inputs sampled there; clock starts low.
// - 2-bit bank select for the current command; low after reset.
// - Row, column, write and chip strobes encode commands; high after reset.
// - Two active-low chip selects; memory obeys commands only while selected.
// - Clock enable high lets memory run its clock, low stops it; high after reset.
// - 4-bit byte mask selects data bytes; low after reset.
// - Names ending in the low suffix assert at 0; others assert at 1.
`timescale 1ns/10ps

module sdp_pin_if (
  // Clock, reset, freeze
  input  wire logic                       clk_sys,
  input  wire logic                       arst_n,
  input  wire logic                       clk_en,
  // Reset pins and PLL lock, asynchronous
  input  wire logic                       power_on_reset_l,
  input  wire logic                       sys_reset_l,
  input  wire logic                       pll_lock,
  // Command port
  input  wire logic                       cmd_valid,
  input  wire sdp_pkg::sdp_cmd_t          cmd_code,
  input  wire logic                       cmd_chip,
  input  wire logic [sdp_pkg::BANK_W-1:0] cmd_bank,
  input  wire logic [sdp_pkg::ADDR_W-1:0] cmd_addr,
  input  wire logic [sdp_pkg::DQ_W-1:0]   cmd_wdata,
  input  wire logic [sdp_pkg::MASK_W-1:0] cmd_mask,
  input  wire logic                       clk_stop_req,
  output logic                            cmd_ready,
  // Read return and status
  output logic [sdp_pkg::DQ_W-1:0]        rd_data,
  output logic                            rd_valid,
  output logic                            pwr_reset_active,
  output logic                            sys_reset_active,
  output logic                            post_reset,
  // Memory pins
  output logic                            mem_clk_fwd,
  output logic [sdp_pkg::ADDR_W-1:0]      mem_addr,
  output logic [sdp_pkg::BANK_W-1:0]      mem_bank_sel,
  output logic                            mem_row_strobe_l,
  output logic                            mem_col_strobe_l,
  output logic                            mem_write_en_l,
  output logic [sdp_pkg::CHIPS-1:0]       mem_chip_sel_l,
  output logic                            mem_clk_enable,
  output logic [sdp_pkg::MASK_W-1:0]      mem_byte_mask,
  output logic                            mem_ctl_oe_l,
  // Memory data bus
  output logic [sdp_pkg::DQ_W-1:0]        mem_dq_out,
  input  wire logic [sdp_pkg::DQ_W-1:0]   mem_dq_in,
  output logic                            mem_dq_oe_l
);

  // Synchronisers
  logic [2:0]                 sync1_ff;
  logic [2:0]                 sync2_ff;
  logic [sdp_pkg::DQ_W-1:0]   dq_sync1_ff;
  logic [sdp_pkg::DQ_W-1:0]   dq_sync2_ff;

  // State
  sdp_pkg::sdp_rst_state_t    state_ff;
  logic                       clk_fwd_ff;
  logic                       ready_ff;
  logic [2:0]                 rd_cnt_ff;
  logic [sdp_pkg::DQ_W-1:0]   rd_data_ff;
  logic                       rd_valid_ff;
  logic                       pwr_rst_ff;
  logic                       sys_rst_ff;
  logic                       post_ff;

  // Pin registers
  logic [sdp_pkg::ADDR_W-1:0] addr_ff;
  logic [sdp_pkg::BANK_W-1:0] bank_ff;
  logic [2:0]                 strb_ff;
  logic [sdp_pkg::CHIPS-1:0]  cs_l_ff;
  logic                       cke_ff;
  logic [sdp_pkg::MASK_W-1:0] mask_ff;
  logic                       ctl_oe_l_ff;
  logic [sdp_pkg::DQ_W-1:0]   dq_out_ff;
  logic                       dq_oe_l_ff;

  // Reset condition decode
  wire por_ok  = sync2_ff[0];
  wire sys_ok  = sync2_ff[1];
  wire lock_ok = sync2_ff[2];

  sdp_pkg::sdp_rst_state_t nxt_state;
  assign nxt_state = !por_ok  ? sdp_pkg::ST_PWR_RESET :
                     !sys_ok  ? sdp_pkg::ST_SYS_RESET :
                     !lock_ok ? sdp_pkg::ST_WAIT_LOCK :
                                sdp_pkg::ST_RUN;

  wire run      = (state_ff == sdp_pkg::ST_RUN);
  wire nxt_run  = (nxt_state == sdp_pkg::ST_RUN);
  wire entering = nxt_run && !run;
  // Launch: clock about to fall, so pins settle half a period before the rise
  wire launch   = run && nxt_run && clk_fwd_ff;
  wire rise     = run && nxt_run && !clk_fwd_ff;

  // Command decode
  wire take     = cmd_valid && ready_ff;
  wire take_rd  = take && (cmd_code == sdp_pkg::CMD_RD);
  wire take_wr  = take && (cmd_code == sdp_pkg::CMD_WR);
  wire take_sel = take && (cmd_code != sdp_pkg::CMD_NOP);
  wire rd_cap   = rise && (rd_cnt_ff == sdp_pkg::RD_CAP_TICK);

  logic [sdp_pkg::CHIPS-1:0] sel_l;
  genvar gi;
  generate
    for (gi = 0; gi < sdp_pkg::CHIPS; gi++) begin : g_cs
      // Unselected chip ignores the strobes, so only one goes low
      assign sel_l[gi] = !(take_sel && (cmd_chip == 1'(gi)));
    end
  endgenerate

  // Next pin values
  wire [2:0] nxt_strb = take ? sdp_pkg::sdp_cmd_pins(cmd_code)
                             : sdp_pkg::STRB_POST;
  wire [sdp_pkg::ADDR_W-1:0] nxt_addr = take ? cmd_addr : addr_ff;
  wire [sdp_pkg::BANK_W-1:0] nxt_bank = take ? cmd_bank : bank_ff;
  wire [sdp_pkg::MASK_W-1:0] nxt_mask = take ? cmd_mask : mask_ff;
  wire                       nxt_cke  = !clk_stop_req;
  // Bus released from read issue until the capture edge
  wire nxt_dq_oe_l = take_rd || ((rd_cnt_ff != 3'h0) && !rd_cap);
  wire [sdp_pkg::DQ_W-1:0] nxt_dq_out = take_wr ? cmd_wdata : sdp_pkg::DQ_POST;
  wire [2:0] nxt_rd_cnt = take_rd ? 3'h1 :
                          rd_cap  ? 3'h0 :
                          (rise && rd_cnt_ff != 3'h0) ? rd_cnt_ff + 3'h1 : rd_cnt_ff;
  wire nxt_clk_fwd = nxt_run && run ? !clk_fwd_ff : sdp_pkg::CLK_POST;
  // Registered ready stands only in a launch cycle and with no read in flight
  wire nxt_ready   = nxt_run && run && !clk_fwd_ff && (nxt_rd_cnt == 3'h0);

  // Pin synchronisers
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sync1_ff    <= 3'h0;
      sync2_ff    <= 3'h0;
      dq_sync1_ff <= 32'h0000_0000;
      dq_sync2_ff <= 32'h0000_0000;
    end else if (clk_en) begin
      sync1_ff    <= {pll_lock, sys_reset_l, power_on_reset_l};
      sync2_ff    <= sync1_ff;
      dq_sync1_ff <= mem_dq_in;
      dq_sync2_ff <= dq_sync1_ff;
    end
  end

  // Reset state and status
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_ff   <= sdp_pkg::ST_PWR_RESET;
      pwr_rst_ff <= 1'h1;
      sys_rst_ff <= 1'h0;
      post_ff    <= 1'h0;
    end else if (clk_en) begin
      state_ff   <= nxt_state;
      pwr_rst_ff <= (nxt_state == sdp_pkg::ST_PWR_RESET);
      sys_rst_ff <= (nxt_state == sdp_pkg::ST_SYS_RESET);
      post_ff    <= nxt_run;
    end
  end

  // Clock, handshake and read tracking
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      clk_fwd_ff  <= sdp_pkg::CLK_POST;
      ready_ff    <= 1'h0;
      rd_cnt_ff   <= 3'h0;
      rd_data_ff  <= 32'h0000_0000;
      rd_valid_ff <= 1'h0;
    end else if (clk_en) begin
      clk_fwd_ff  <= nxt_clk_fwd;
      ready_ff    <= nxt_ready;
      rd_cnt_ff   <= nxt_run ? nxt_rd_cnt : 3'h0;
      rd_valid_ff <= rd_cap;
      if (rd_cap) begin
        rd_data_ff <= dq_sync2_ff;
      end
    end
  end

  // Output enables: float in any reset, drive from the first run cycle
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ctl_oe_l_ff <= 1'h1;
      dq_oe_l_ff  <= 1'h1;
    end else if (clk_en) begin
      ctl_oe_l_ff <= !nxt_run;
      if (!nxt_run || entering) begin
        dq_oe_l_ff <= !nxt_run;
      end else if (launch || rd_cap) begin
        dq_oe_l_ff <= nxt_dq_oe_l;
      end
    end
  end

  // Command and data pins: post-reset levels until a launch changes them
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      addr_ff   <= sdp_pkg::ADDR_POST;
      bank_ff   <= sdp_pkg::BANK_POST;
      strb_ff   <= sdp_pkg::STRB_POST;
      cs_l_ff   <= sdp_pkg::CS_POST;
      cke_ff    <= sdp_pkg::CKE_POST;
      mask_ff   <= sdp_pkg::MASK_POST;
      dq_out_ff <= sdp_pkg::DQ_POST;
    end else if (clk_en) begin
      if (!run) begin
        addr_ff   <= sdp_pkg::ADDR_POST;
        bank_ff   <= sdp_pkg::BANK_POST;
        strb_ff   <= sdp_pkg::STRB_POST;
        cs_l_ff   <= sdp_pkg::CS_POST;
        cke_ff    <= sdp_pkg::CKE_POST;
        mask_ff   <= sdp_pkg::MASK_POST;
        dq_out_ff <= sdp_pkg::DQ_POST;
      end else if (launch) begin
        addr_ff   <= nxt_addr;
        bank_ff   <= nxt_bank;
        strb_ff   <= nxt_strb;
        cs_l_ff   <= sel_l;
        cke_ff    <= nxt_cke;
        mask_ff   <= nxt_mask;
        dq_out_ff <= nxt_dq_out;
      end
    end
  end

  // Active-low pins carry the _l suffix and idle at 1
  assign mem_row_strobe_l = strb_ff[2];
  assign mem_col_strobe_l = strb_ff[1];
  assign mem_write_en_l   = strb_ff[0];
  assign mem_chip_sel_l   = cs_l_ff;
  assign mem_clk_fwd      = clk_fwd_ff;
  assign mem_addr         = addr_ff;
  assign mem_bank_sel     = bank_ff;
  assign mem_clk_enable   = cke_ff;
  assign mem_byte_mask    = mask_ff;
  assign mem_ctl_oe_l     = ctl_oe_l_ff;
  assign mem_dq_out       = dq_out_ff;
  assign mem_dq_oe_l      = dq_oe_l_ff;
  assign cmd_ready        = ready_ff;
  assign rd_data          = rd_data_ff;
  assign rd_valid         = rd_valid_ff;
  assign pwr_reset_active = pwr_rst_ff;
  assign sys_reset_active = sys_rst_ff;
  assign post_reset       = post_ff;

endmodule : sdp_pin_if

/* tb/sdp_pin_if_props.sv */
// Concurrent checks on the SDRAM pin interface ports.
// Assumes binding into every sdp_pin_if instance; one clock domain.
`timescale 1ns/10ps

module sdp_pin_if_props (
  // Clock, reset and command side
  input wire logic                        clk_sys, arst_n, clk_en, cmd_valid, cmd_ready, cmd_chip, clk_stop_req,
  input wire logic                        rd_valid,
  input wire sdp_pkg::sdp_cmd_t           cmd_code,
  input wire logic [sdp_pkg::ADDR_W-1:0]  cmd_addr, mem_addr,
  input wire logic [sdp_pkg::BANK_W-1:0]  cmd_bank, mem_bank_sel,
  input wire logic [sdp_pkg::MASK_W-1:0]  cmd_mask, mem_byte_mask,
  input wire logic [sdp_pkg::DQ_W-1:0]    cmd_wdata, mem_dq_out,
  // Status and memory pins
  input wire logic                        pwr_reset_active, sys_reset_active, post_reset, mem_clk_fwd,
  input wire logic                        mem_row_strobe_l, mem_col_strobe_l, mem_write_en_l, mem_clk_enable,
  input wire logic                        mem_ctl_oe_l, mem_dq_oe_l,
  input wire logic [sdp_pkg::CHIPS-1:0]   mem_chip_sel_l
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  wire       take = cmd_valid && cmd_ready && clk_en;
  wire [2:0] strb = {mem_row_strobe_l, mem_col_strobe_l, mem_write_en_l};
  wire       idle = (strb == 3'h7) && (mem_chip_sel_l == 2'h3);

  a_reset_float: assert property ((pwr_reset_active || sys_reset_active) |-> mem_ctl_oe_l && mem_dq_oe_l)
    else $error("memory pins driven during reset");
  a_drive_run_only: assert property (!mem_ctl_oe_l |-> post_reset)
    else $error("control pins driven outside run");
  a_status_onehot: assert property ($onehot0({pwr_reset_active, sys_reset_active, post_reset}))
    else $error("reset status bits overlap");
  a_clk_toggle: assert property (post_reset && clk_en ##1 post_reset |-> mem_clk_fwd != $past(mem_clk_fwd))
    else $error("forwarded clock did not toggle");
  a_write_launch: assert property (take && cmd_code == sdp_pkg::CMD_WR |=> strb == 3'h4 && !mem_clk_fwd
    && mem_chip_sel_l == ($past(cmd_chip) ? 2'h1 : 2'h2) && mem_addr == $past(cmd_addr) && !mem_dq_oe_l
    && mem_bank_sel == $past(cmd_bank) && mem_byte_mask == $past(cmd_mask) && mem_dq_out == $past(cmd_wdata))
    else $error("write launch pins wrong");
  a_cmd_hold: assert property (take ##1 clk_en |=> $stable(strb) && $stable(mem_chip_sel_l))
    else $error("command strobes did not stand one memory clock");
  a_read_return: assert property (take && cmd_code == sdp_pkg::CMD_RD |-> ##[2:12] rd_valid)
    else $error("read data not returned in time");
  a_cke_follow: assert property (take |=> mem_clk_enable == !$past(clk_stop_req))
    else $error("clock enable does not follow stop request");
  a_dq_idle_high: assert property (!mem_dq_oe_l && idle |-> mem_dq_out == sdp_pkg::DQ_POST)
    else $error("idle data bus not driven high");
  a_post_levels: assert property ($rose(post_reset) |-> idle && !mem_ctl_oe_l && !mem_dq_oe_l && !mem_clk_fwd
    && mem_addr == 13'h0 && mem_bank_sel == 2'h0 && mem_byte_mask == 4'h0 && mem_clk_enable)
    else $error("post reset pin levels wrong");

  c_write: cover property (take && cmd_code == sdp_pkg::CMD_WR);
  c_read: cover property (rd_valid);
  c_rerun: cover property ($fell(post_reset));
endmodule : sdp_pin_if_props

bind sdp_pin_if sdp_pin_if_props u_sdp_pin_if_props (.*);

/* tb/sdp_mem_model.sv */
// SDRAM stand-in: one word per chip, commands decoded at the forwarded clock's rise.
// Assumes the interface floats its pins through active-low enables.
`timescale 1ns/10ps

module sdp_mem_model (
  // Pins from the interface
  input  wire logic        mem_clk_fwd, mem_row_strobe_l, mem_col_strobe_l, mem_write_en_l,
  input  wire logic [1:0]  mem_chip_sel_l,
  input  wire logic [3:0]  mem_byte_mask,
  input  wire logic        mem_ctl_oe_l, mem_dq_oe_l,
  input  wire logic [31:0] mem_dq_out,
  // Level seen at the data pads
  output logic      [31:0] mem_dq_in
);
  logic [31:0] word_q [2];
  logic [31:0] last_q = 32'h0;
  logic [2:0]  lat_q = 3'h0;
  logic        drive_q = 1'b0;
  logic        rd_chip_q = 1'b0;
  wire  [2:0]  strb = {mem_row_strobe_l, mem_col_strobe_l, mem_write_en_l};
  wire         hit = !mem_ctl_oe_l && (mem_chip_sel_l != 2'h3);
  wire         chip = mem_chip_sel_l[0];
  // Released bus shows the inverse of the last word, so stale data never passes
  assign mem_dq_in = !mem_dq_oe_l ? mem_dq_out : (drive_q ? last_q : ~last_q);
  initial begin
    word_q[0] = 32'h0;
    word_q[1] = 32'h0;
  end
  always @(posedge mem_clk_fwd) begin
    if (hit && strb == 3'h4) begin
      for (int i = 0; i < 4; i++) begin
        if (!mem_byte_mask[i]) word_q[chip][8*i+:8] <= mem_dq_out[8*i+:8];
      end
    end
    if (hit && strb == 3'h5) begin
      lat_q <= 3'h1;
      rd_chip_q <= chip;
    end else if (lat_q != 3'h0) begin
      lat_q <= lat_q + 3'h1;
    end
    // Data launched one clock early so it is settled at the latency edge and one edge past it
    drive_q <= (lat_q == 3'h1) || (lat_q == sdp_pkg::CAS_LAT_CLKS);
    if (lat_q == 3'h1) last_q <= word_q[rd_chip_q];
  end
endmodule : sdp_mem_model

/* tb/tb_sdp_pin_if.sv */
// Self-checking bench for the SDRAM pin interface against a memory stand-in.
// Assumes a 100 MHz clock; inputs change on the falling edge.
`timescale 1ns/10ps

module tb_sdp_pin_if;
  logic clk_sys = 1'b0, arst_n = 1'b0, clk_en = 1'b1, power_on_reset_l = 1'b0, sys_reset_l = 1'b0;
  logic pll_lock = 1'b0, cmd_valid = 1'b0, cmd_chip = 1'b0, clk_stop_req = 1'b0;
  sdp_pkg::sdp_cmd_t cmd_code = sdp_pkg::CMD_NOP;
  logic [1:0]  cmd_bank = 2'h0, mem_bank_sel, mem_chip_sel_l;
  logic [12:0] cmd_addr = 13'h0, mem_addr;
  logic [31:0] cmd_wdata = 32'h0, mem_dq_in, rd_data, mem_dq_out;
  logic [3:0]  cmd_mask = 4'h0, mem_byte_mask;
  logic cmd_ready, rd_valid, pwr_reset_active, sys_reset_active, post_reset, mem_clk_fwd, mem_clk_enable;
  logic mem_row_strobe_l, mem_col_strobe_l, mem_write_en_l, mem_ctl_oe_l, mem_dq_oe_l;
  logic [2:0] pins [7] = '{3'h7, 3'h3, 3'h5, 3'h4, 3'h2, 3'h1, 3'h0};
  int err_count = 0, check_count = 0, cycles = 0;

  always #5 clk_sys = ~clk_sys;
  sdp_pin_if u_sdp_pin_if (.*);
  sdp_mem_model u_sdp_mem_model (.*);

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict

  // Holds valid until ready is seen, so a refused cycle simply retries
  task automatic issue(input sdp_pkg::sdp_cmd_t c, input logic ch, input logic [31:0] d, input logic [3:0] m);
    cmd_code = c;
    cmd_chip = ch;
    cmd_wdata = d;
    cmd_mask = m;
    cmd_addr = 13'h1abc;
    cmd_bank = 2'h2;
    cmd_valid = 1'b1;
    for (int n = 0; n < 40 && cmd_ready !== 1'b1; n++) @(negedge clk_sys);
    @(negedge clk_sys);
    cmd_valid = 1'b0;
  endtask : issue

  task automatic wait_post();
    for (int n = 0; n < 30 && post_reset !== 1'b1; n++) @(negedge clk_sys);
    check("post_reset", post_reset, 1'b1);
    check("drive enables", {mem_ctl_oe_l, mem_dq_oe_l}, 2'h0);
    check("addr", mem_addr, 13'h0);
    check("dq", mem_dq_out, 32'hffff_ffff);
    check("fwd clock", mem_clk_fwd, 1'b0);
    check("bank", mem_bank_sel, 2'h0);
    check("strobes cs", {mem_row_strobe_l, mem_col_strobe_l, mem_write_en_l, mem_chip_sel_l}, 5'h1f);
    check("cke", mem_clk_enable, 1'b1);
    check("mask", mem_byte_mask, 4'h0);
  endtask : wait_post

  task automatic test_resets();
    sys_reset_l = 1'b1;
    pll_lock = 1'b1;
    repeat (5) @(negedge clk_sys);
    check("pwr active", {pwr_reset_active, sys_reset_active}, 2'h2);
    check("float pwr", {mem_ctl_oe_l, mem_dq_oe_l}, 2'h3);
    power_on_reset_l = 1'b1;
    sys_reset_l = 1'b0;
    repeat (5) @(negedge clk_sys);
    check("sys active", {pwr_reset_active, sys_reset_active}, 2'h1);
    check("float sys", {mem_ctl_oe_l, mem_dq_oe_l}, 2'h3);
    sys_reset_l = 1'b1;
    pll_lock = 1'b0;
    repeat (5) @(negedge clk_sys);
    check("no lock", {post_reset, mem_ctl_oe_l}, 2'h1);
    pll_lock = 1'b1;
    wait_post();
    $display("resets done");
  endtask : test_resets

  task automatic test_codes();
    for (int i = 0; i < 7; i++) begin
      issue(sdp_pkg::sdp_cmd_t'(i), 1'b1, 32'h0, 4'h0);
      check("strobes", {mem_row_strobe_l, mem_col_strobe_l, mem_write_en_l}, pins[i]);
      check("chip sel", mem_chip_sel_l, (i == 0) ? 2'h3 : 2'h1);
    end
    check("addr bank", {mem_addr, mem_bank_sel}, {13'h1abc, 2'h2});
    $display("codes done");
  endtask : test_codes

  task automatic read_check(input logic ch, input logic [31:0] exp);
    issue(sdp_pkg::CMD_RD, ch, 32'h0, 4'h0);
    check("dq released", mem_dq_oe_l, 1'b1);
    for (int n = 0; n < 20 && rd_valid !== 1'b1; n++) @(negedge clk_sys);
    check("rd_valid", rd_valid, 1'b1);
    check("rd_data", rd_data, exp);
  endtask : read_check

  task automatic test_data();
    issue(sdp_pkg::CMD_WR, 1'b0, 32'h1234_5678, 4'h0);
    check("write dq", mem_dq_out, 32'h1234_5678);
    issue(sdp_pkg::CMD_WR, 1'b0, 32'hcafe_beef, 4'h5);
    check("write mask", mem_byte_mask, 4'h5);
    issue(sdp_pkg::CMD_WR, 1'b1, 32'h0bad_f00d, 4'h0);
    read_check(1'b0, 32'hca34_be78);
    read_check(1'b1, 32'h0bad_f00d);
    clk_stop_req = 1'b1;
    issue(sdp_pkg::CMD_NOP, 1'b0, 32'h0, 4'h0);
    check("cke stop", mem_clk_enable, 1'b0);
    clk_stop_req = 1'b0;
    issue(sdp_pkg::CMD_NOP, 1'b0, 32'h0, 4'h0);
    check("cke run", mem_clk_enable, 1'b1);
    $display("data done");
  endtask : test_data

  task automatic test_midreset();
    sys_reset_l = 1'b0;
    for (int n = 0; n < 10 && mem_ctl_oe_l !== 1'b1; n++) @(negedge clk_sys);
    repeat (2) @(negedge clk_sys);
    check("mid float", {sys_reset_active, mem_ctl_oe_l, mem_dq_oe_l, mem_clk_fwd}, 4'he);
    sys_reset_l = 1'b1;
    wait_post();
    $display("mid reset done");
  endtask : test_midreset

  initial begin
    repeat (6) @(negedge clk_sys);
    arst_n = 1'b1;
    test_resets();
    test_codes();
    test_data();
    test_midreset();
    give_verdict();
  end

  // Whole run is roughly eighty cycles; the ceiling only catches a hang
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_count++;
      give_verdict();
    end
  end
endmodule : tb_sdp_pin_if
